/* File: rtl/cfb_defs.vh */
// Purpose: constants for the clock fanout serial configuration block
// Assumes: included by cfb_top only; cfb_sync and cfb_pair do not include it
// Notes:   definitions only
`ifndef CFB_DEFS_VH
`define CFB_DEFS_VH
`define CFB_NUM_PAIRS   10
`define CFB_SHIFT_LEN   11
`define CFB_SEL_BIT     10
`define CFB_ST_LOAD     2'h0
`define CFB_ST_ARMED    2'h1
`define CFB_ST_DONE     2'h2
`endif

/* File: rtl/cfb_sync.v */
// Purpose: two flip-flop synchroniser for one level
// Assumes: i_clk is the block clock
// Notes:   first stage read only by the second stage
`timescale 1ns/1ns
`default_nettype none
module cfb_sync (
    input  wire i_clk,
    input  wire i_rst_n,
    input  wire i_async,
    output reg  o_sync
);
    reg meta;

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            meta   <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/cfb_pair.v */
// Purpose: one differential output pair
// Assumes: selected clock already chosen and fail-safe resolved
// Notes:   disabled pair drives both legs low (powered off)
`timescale 1ns/1ns
`default_nettype none
module cfb_pair (
    input  wire i_clk,
    input  wire i_rst_n,
    input  wire i_en,
    input  wire i_true,
    input  wire i_comp,
    output reg  o_true,
    output reg  o_comp
);
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_true <= 1'b0;
            o_comp <= 1'b0;
        end else if (i_en) begin
            o_true <= i_true;
            o_comp <= i_comp;
        end else begin
            o_true <= 1'b0;
            o_comp <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/cfb_top.v */
// Purpose: serial configuration and selection of a 1:10 clock fanout
// Assumes: all pins asynchronous to i_clk, sampled by two flip-flops;
//          config clock period well above four i_clk periods
// Notes:   reference clocks are sampled too, so outputs are a sampled copy
`timescale 1ns/1ns
`default_nettype none
`include "cfb_defs.vh"

module cfb_top #(
    parameter NUM_PAIRS = `CFB_NUM_PAIRS,
    parameter SHIFT_LEN = `CFB_SHIFT_LEN
) (
    input  wire                 i_clk,
    input  wire                 i_rst_n,
    input  wire                 i_config_shift_clock,
    input  wire                 i_serial_data,
    input  wire                 i_program_enable,
    input  wire                 i_ref_input_a,
    input  wire                 i_ref_input_a_n,
    input  wire                 i_ref_input_b,
    input  wire                 i_ref_input_b_n,
    output wire [NUM_PAIRS-1:0] o_output_pair,
    output wire [NUM_PAIRS-1:0] o_output_pair_n,
    output reg  [SHIFT_LEN-1:0] o_control,
    output reg  [1:0]           o_state
);
    localparam ST_LOAD  = `CFB_ST_LOAD;
    localparam ST_ARMED = `CFB_ST_ARMED;
    localparam ST_DONE  = `CFB_ST_DONE;
    localparam SEL_BIT  = `CFB_SEL_BIT;

    // config pins, each through two flops
    wire sck_s;
    wire sdi_s;
    wire pen_s;
    wire ra_s;
    wire ra_n_s;
    wire rb_s;
    wire rb_n_s;

    cfb_sync u_sck (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_async (i_config_shift_clock),
        .o_sync  (sck_s)
    );

    cfb_sync u_sdi (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_async (i_serial_data),
        .o_sync  (sdi_s)
    );

    cfb_sync u_pen (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_async (i_program_enable),
        .o_sync  (pen_s)
    );

    // reference legs too, so the outputs are a sampled copy
    cfb_sync u_ra (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_async (i_ref_input_a),
        .o_sync  (ra_s)
    );

    cfb_sync u_ran (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_async (i_ref_input_a_n),
        .o_sync  (ra_n_s)
    );

    cfb_sync u_rb (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_async (i_ref_input_b),
        .o_sync  (rb_s)
    );

    cfb_sync u_rbn (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_async (i_ref_input_b_n),
        .o_sync  (rb_n_s)
    );

    reg                 sck_d;
    reg [SHIFT_LEN-1:0] shift;
    reg [3:0]           count;
    reg [1:0]           next_state;
    reg [SHIFT_LEN-1:0] next_shift;
    reg [SHIFT_LEN-1:0] next_control;
    reg [3:0]           next_count;

    // data and enable share the clock's sync delay, so they line up
    wire sck_rise;
    wire clear_req;
    wire step_req;
    wire last_bit;

    assign sck_rise  = sck_s & ~sck_d;
    assign clear_req = sck_rise & ~pen_s;
    assign step_req  = sck_rise & pen_s;
    assign last_bit  = (count == SHIFT_LEN - 1);

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            sck_d <= 1'b0;
        end else begin
            sck_d <= sck_s;
        end
    end

    // state moves only on a rise; enable low restarts it
    always @* begin
        next_state = o_state;
        if (clear_req) begin
            next_state = ST_LOAD;
        end else if (step_req) begin
            case (o_state)
                ST_LOAD: begin
                    if (last_bit) begin
                        next_state = ST_ARMED;
                    end
                end
                ST_ARMED: begin
                    next_state = ST_DONE;
                end
                ST_DONE: begin
                    next_state = ST_DONE;
                end
                default: begin
                    next_state = ST_LOAD;
                end
            endcase
        end
    end

    // shift register and bit counter step only while loading
    always @* begin
        next_shift = shift;
        next_count = count;
        if (clear_req) begin
            next_shift = {SHIFT_LEN{1'b0}};
            next_count = 4'h0;
        end else if (step_req && o_state == ST_LOAD) begin
            // first bit in walks down to bit 0 after eleven steps
            next_shift = {sdi_s, shift[SHIFT_LEN-1:1]};
            next_count = count + 4'h1;
        end
    end

    // the register takes one copy per reset, on the step after loading
    always @* begin
        next_control = o_control;
        if (clear_req) begin
            next_control = {SHIFT_LEN{1'b0}};
        end else if (step_req) begin
            case (o_state)
                ST_ARMED: begin
                    next_control = shift;
                end
                ST_DONE: begin
                    next_control = o_control;
                end
                default: begin
                    next_control = o_control;
                end
            endcase
        end
    end

    // power-up clear via i_rst_n stands in for an explicit pin reset
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_state <= ST_LOAD;
        end else begin
            o_state <= next_state;
        end
    end

    // shift register
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            shift <= {SHIFT_LEN{1'b0}};
        end else begin
            shift <= next_shift;
        end
    end

    // control register
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_control <= {SHIFT_LEN{1'b0}};
        end else begin
            o_control <= next_control;
        end
    end

    // bit counter
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            count <= 4'h0;
        end else begin
            count <= next_count;
        end
    end

    // control bit 0 holds the first serial bit, which drives pair 9
    wire [NUM_PAIRS-1:0] prog_en;
    genvar g;
    generate
        for (g = 0; g < NUM_PAIRS; g = g + 1) begin : g_map
            assign prog_en[g] = o_control[NUM_PAIRS-1-g];
        end
    endgenerate

    // last serial bit sits in bit 10 and picks the reference
    wire                sel_prog;
    reg                 sel;
    reg [NUM_PAIRS-1:0] en_all;

    assign sel_prog = o_control[SEL_BIT];

    // standard mode ignores the register contents altogether
    always @* begin
        if (pen_s) begin
            sel = sel_prog;
        end else begin
            sel = sdi_s;
        end
    end

    always @* begin
        if (pen_s) begin
            en_all = prog_en;
        end else begin
            en_all = {NUM_PAIRS{1'b1}};
        end
    end

    // selected reference, before the fail-safe check
    reg src_t;
    reg src_c;
    reg out_t;
    reg out_c;

    always @* begin
        if (sel) begin
            src_t = rb_s;
            src_c = rb_n_s;
        end else begin
            src_t = ra_s;
            src_c = ra_n_s;
        end
    end

    // open or shorted input reads both legs equal
    always @* begin
        if (src_t ^ src_c) begin
            out_t = src_t;
            out_c = src_c;
        end else begin
            out_t = 1'b0;
            out_c = 1'b1;
        end
    end

    // every pair sees the same source; the enable gates it per pair
    generate
        for (g = 0; g < NUM_PAIRS; g = g + 1) begin : g_pair
            cfb_pair u_pair (
                .i_clk   (i_clk),
                .i_rst_n (i_rst_n),
                .i_en    (en_all[g]),
                .i_true  (out_t),
                .i_comp  (out_c),
                .o_true  (o_output_pair[g]),
                .o_comp  (o_output_pair_n[g])
            );
        end
    endgenerate
endmodule
`default_nettype wire

/* File: test/cfb_asserts.sv */
// Purpose: checks on config state and control register
// Assumes: pins held 3 clocks around config clock edges
// Notes:   pin effects land 2 to 5 clocks late
`timescale 1ns/1ns
`default_nettype none
module cfb_asserts #(
    parameter SHIFT_LEN = 11
) (
    input wire logic                 i_clk,
    input wire logic                 i_rst_n,
    input wire logic                 i_config_shift_clock,
    input wire logic                 i_program_enable,
    input wire logic [SHIFT_LEN-1:0] o_control,
    input wire logic [1:0]           o_state
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_clear_low: assert property (
        $rose(i_config_shift_clock) && !i_program_enable
        |-> ##[2:5] o_state == 2'h0 && o_control == '0) else $error("clear");
    a_load_xfer: assert property (
        $rose(i_config_shift_clock) && i_program_enable && o_state == 2'h1
        |-> ##[2:5] o_state == 2'h2) else $error("transfer");
    a_done_holds: assert property (
        o_state == 2'h2 && i_program_enable && $past(i_program_enable, 6)
        |=> $stable(o_control)) else $error("reload");
    a_ctrl_cause: assert property (
        !$stable(o_control) |-> $past(i_config_shift_clock, 3)
        || $past(i_config_shift_clock, 4)) else $error("ctrl cause");
    a_state_cause: assert property (
        $changed(o_state) |-> $past(i_config_shift_clock, 3)
        || $past(i_config_shift_clock, 4)) else $error("state cause");
    a_ctrl_idle: assert property (
        o_state != 2'h2 |-> o_control == '0) else $error("ctrl early");
    a_done_order: assert property (
        $changed(o_state) && o_state == 2'h2 |-> $past(o_state) == 2'h1)
        else $error("order");
    a_state_legal: assert property (
        o_state != 2'h3) else $error("state");
endmodule
bind cfb_top cfb_asserts #(.SHIFT_LEN(SHIFT_LEN)) i_cfb_asserts (.*);
`default_nettype wire

/* File: test/cfb_ctrl_model.sv */
// Purpose: board controller on the config pins
// Assumes: 160 ns config clock, idle low between frames
// Notes:   data shows its inverse once hold has ended
`timescale 1ns/1ns
`default_nettype none
module cfb_ctrl_model (
    output var logic o_sck = 1'b0,
    output var logic o_sd = 1'b0,
    output var logic o_pe = 1'b0
);
    task automatic hold(input logic pe, input logic sd);
        o_pe = pe;
        o_sd = sd;
    endtask
    task automatic pulse(input logic d);
        o_sd = d;
        #80 o_sck = 1'b1;
        #60 o_sd = ~d;
        #20 o_sck = 1'b0;
    endtask
    // bit 0 of v goes out first
    task automatic load(input logic [12:0] v, input int n);
        o_pe = 1'b0;
        pulse(1'b0);
        o_pe = 1'b1;
        for (int k = 0; k < n; k++) pulse(v[k]);
    endtask
endmodule
`default_nettype wire

/* File: test/test_clock_fanout_serial_config.sv */
// Purpose: self-checking bench for the fanout config block
// Assumes: partner model drives the config pins
// Notes:   a clear pulse then 13 data pulses per load, the last data pulse must be ignored
`timescale 1ns/1ns
`default_nettype none
module test_clock_fanout_serial_config;
    logic        i_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [3:0]  r = 4'h0;
    logic [12:0] v;
    logic [10:0] ctl;
    wire         i_config_shift_clock, i_serial_data, i_program_enable;
    wire  [9:0]  o_output_pair, o_output_pair_n;
    wire  [10:0] o_control;
    wire  [1:0]  o_state;
    int          err_total = 0, n_compared = 0, cyc = 0;
    int          seed = 32'hd3672b0b;
    always #10 i_clk = ~i_clk;
    cfb_ctrl_model i_cfb_ctrl_model (.o_sck(i_config_shift_clock),
        .o_sd(i_serial_data), .o_pe(i_program_enable));
    cfb_top i_cfb_top (.*, .i_ref_input_a(r[3]), .i_ref_input_a_n(r[2]),
        .i_ref_input_b(r[1]), .i_ref_input_b_n(r[0]));
    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // disabled pair rests at 0/0, idle input gives true low
    function automatic logic [19:0] want(input logic [10:0] c);
        logic       t;
        logic [9:0] on;
        t = (i_program_enable ? c[10] : i_serial_data) ? r[1] & ~r[0]
            : r[3] & ~r[2];
        for (int g = 0; g < 10; g++) on[g] = !i_program_enable || c[9 - g];
        return {on & {10{t}}, on & {10{~t}}};
    endfunction
    always @(posedge i_clk) if (++cyc == 5000) begin
        err_total++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge i_clk);
        #2 i_rst_n = 1'b1;
        repeat (4) @(posedge i_clk);
        #1 check({7'h0, o_control, o_state}, 20'h0);
        for (int i = 0; i < 6; i++) begin
            v = i < 2 ? {13{i[0]}} : 13'($random(seed));
            ctl = v[10:0];
            @(posedge i_clk);
            #2 i_cfb_ctrl_model.load(v, 13);
            repeat (8) @(posedge i_clk);
            #1 check({7'h0, o_control, o_state}, {7'h0, ctl, 2'h2});
            for (int j = 0; j < 4; j++) begin
                @(posedge i_clk);
                v = 13'($random(seed));
                #2 i_cfb_ctrl_model.hold(v[0], v[1]);
                r = v[5:2];
                repeat (8) @(posedge i_clk);
                #1 check({o_output_pair, o_output_pair_n}, want(ctl));
            end
        end
        @(posedge i_clk);
        #2 i_cfb_ctrl_model.load(v, 0);
        repeat (8) @(posedge i_clk);
        #1 check({7'h0, o_control, o_state}, 20'h0);
        summarize();
    end
endmodule
`default_nettype wire
